// file: test/temp_host_model.sv
`default_nettype none
module temp_host_model (
  input wire logic SYS_CLK,
  output var temp_limits_pkg::reg_req_t REQ,
  input wire logic [7:0] RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    REQ = '{wr: 1'b0, rd: 1'b0, addr: 8'hA5, wdata: 8'h5A};
  end
  // ----------------------------------------
  // one register access, request held one full cycle
  // ----------------------------------------
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(negedge SYS_CLK);
    REQ = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(negedge SYS_CLK);
    // released lines show the inverse so a stale value cannot pass
    REQ = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    @(negedge SYS_CLK);
    rdata = RDATA;
  endtask : access
  // upper byte always fetched before the fraction byte
  task automatic read_remote(output logic [7:0] upper, output logic [7:0] frac);
    access(1'b0, 8'h01, 8'h00, upper);
    access(1'b0, 8'h10, 8'h00, frac);
  endtask : read_remote
endmodule : temp_host_model
`default_nettype wire

// file: test/temp_result_limit_regs_test.sv
`default_nettype none
module temp_result_limit_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  temp_limits_pkg::reg_req_t req;
  temp_limits_pkg::conv_t conv = '0;
  temp_limits_pkg::filt_t filter_sel;
  logic [7:0] rdata;
  logic alert_cmp_en;
  logic alert_level;
  logic crit_active;
  logic [7:0] rv;
  logic [7:0] fv;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] rst_tab [10] = '{16'h0546, 16'h0746, 16'h1300, 16'h0800, 16'h1400, 16'h1955, 16'h210A, 16'hBF00,
    16'h1100, 16'h1200};
  logic [7:0] filt_exp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
  always #2.5 SYS_CLK = ~SYS_CLK;
  temp_limit_regs temp_limit_regs_inst (.SYS_CLK(SYS_CLK), .RST(RST), .REQ(req), .RDATA(rdata), .CONV(conv),
    .FILTER_SEL(filter_sel), .ALERT_CMP_EN(alert_cmp_en), .ALERT_LEVEL(alert_level), .CRIT_ACTIVE(crit_active));
  temp_host_model temp_host_model_inst (.SYS_CLK(SYS_CLK), .REQ(req), .RDATA(rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    temp_host_model_inst.access(1'b1, a, d, rv);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    temp_host_model_inst.access(1'b0, a, 8'h00, rv);
    check(rv, e);
  endtask : rd_chk
  // c0 valid, c1 registers, c2 status and critical state: wait past all three
  task automatic convert(input logic [7:0] d, input logic [10:0] r);
    @(negedge SYS_CLK);
    conv = '{d, r, 1'b1};
    @(negedge SYS_CLK);
    conv = '{~d, ~r, 1'b0};
    repeat (3) @(negedge SYS_CLK);
  endtask : convert
  task automatic clear_status();
    convert(8'h20, 11'h100);
    temp_host_model_inst.access(1'b0, 8'h02, 8'h00, rv);
    temp_host_model_inst.access(1'b0, 8'h02, 8'h00, rv);
  endtask : clear_status
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // a full run needs well under a thousand cycles
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST = 1'b0;
    foreach (rst_tab[i]) begin
      rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
    end
    $display("test reset values done");
    wr(8'h05, 8'hA5);
    rd_chk(8'h05, 8'hA5);
    convert(8'h30, 11'h100);
    wr(8'h00, 8'h77);
    rd_chk(8'h00, 8'h30);
    rd_chk(8'h40, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h12, 8'h20);
    convert(8'h30, {8'h20, 3'b010});
    temp_host_model_inst.read_remote(rv, fv);
    check(rv, 8'h21);
    check(fv, 8'h60);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    convert(8'h30, 11'h7F4);
    temp_host_model_inst.read_remote(rv, fv);
    check(rv, 8'hFE);
    check(fv, 8'h80);
    $display("test readings done");
    wr(8'h19, 8'h60);
    rd_chk(8'h19, 8'h55);
    wr(8'h03, 8'h02);
    wr(8'h19, 8'h60);
    rd_chk(8'h19, 8'h60);
    wr(8'h19, 8'h70);
    rd_chk(8'h19, 8'h60);
    convert(8'h20, {8'h61, 3'b000});
    check({7'h00, crit_active}, 8'h01);
    convert(8'h20, {8'h58, 3'b000});
    check({7'h00, crit_active}, 8'h01);
    convert(8'h20, {8'h55, 3'b000});
    check({7'h00, crit_active}, 8'h00);
    $display("test critical limit done");
    clear_status();
    wr(8'h05, 8'h46);
    convert(8'h50, {8'h47, 3'b000});
    check({7'h00, alert_level}, 8'h01);
    rd_chk(8'h02, 8'h50);
    convert(8'h20, 11'h100);
    rd_chk(8'h02, 8'h50);
    rd_chk(8'h02, 8'h00);
    check({7'h00, alert_level}, 8'h00);
    wr(8'h08, 8'h10);
    wr(8'h14, 8'h20);
    convert(8'h20, {8'h10, 3'b000});
    rd_chk(8'h02, 8'h08);
    wr(8'hBF, 8'h01);
    check({7'h00, alert_cmp_en}, 8'h01);
    convert(8'h20, 11'h100);
    check({7'h00, alert_level}, 8'h00);
    clear_status();
    $display("test status done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hBF, 8'(2 * i));
      check({6'h00, filter_sel}, filt_exp[i]);
    end
    $display("test filter done");
    print_verdict();
  end
endmodule : temp_result_limit_regs_test
`default_nettype wire

// file: verilog/limit_compare.sv
`default_nettype none
`include "temp_limits_map.svh"
module limit_compare (
  input wire logic [10:0] remote,
  input wire logic [7:0] die,
  input wire logic [7:0] die_high,
  input wire logic [10:0] rhigh,
  input wire logic [10:0] rlow,
  input wire logic [7:0] crit,
  input wire logic [7:0] hyst,
  input wire logic crit_active,
  output logic die_over,
  output logic remote_over,
  output logic remote_under,
  output logic crit_next
);
  logic signed [8:0] release_lvl;
  logic signed [8:0] remote_int;
  assign release_lvl = $signed({crit[7], crit}) - $signed({1'b0, hyst});
  assign remote_int = $signed({remote[10], remote[10:3]});
  assign die_over = $signed(die) > $signed(die_high);
  assign remote_over = $signed(remote) > $signed(rhigh);
  assign remote_under = $signed(remote) < $signed(rlow);
  // hysteresis: hold until below limit minus hysteresis
  assign crit_next = crit_active ? !(remote_int < release_lvl)
                                 : ($signed(remote[10:3]) > $signed(crit));
endmodule : limit_compare
`default_nettype wire

// file: verilog/temp_limit_regs.sv
// Contract
// - read-only die temperature integer register
// - read/write die high limit, resets to 0x46
// - remote upper byte is two's complement integer degrees
// - remote lower byte fraction in bits 7:5, bits 4:0 zero
// - correction offset added to converter output gives reported remote reading
// - remote high limit two bytes, upper resets 0x46, lower zero
// - remote low limit two bytes, both reset zero
// - critical limit integer resets to 0x55
// - critical limit writable only after config unlock bit 1 set
// - after one reprogramming critical limit locked until reset
// - critical stays active until remote below limit minus hysteresis
// - filter field: 00 off, 01/10 minimal, 11 maximum
// - comparator mode bit 0 makes pin follow alarm condition
// - alarm bits latched until status read, then clear if gone
// - status bit 4 on remote above high limit
// - status bit 3 on remote under low limit
// - status bit 6 on die above its high limit
`default_nettype none
`include "temp_limits_map.svh"
module temp_limit_regs (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire temp_limits_pkg::reg_req_t REQ,
  output logic [7:0] RDATA,
  input wire temp_limits_pkg::conv_t CONV,
  output temp_limits_pkg::filt_t FILTER_SEL,
  output logic ALERT_CMP_EN,
  output logic ALERT_LEVEL,
  output logic CRIT_ACTIVE
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] die_q, die_high_q, rhigh_u_q, rlow_u_q, crit_q, hyst_q, cfg_q, filt_q;
  logic [2:0] rhigh_f_q, rlow_f_q, corr_f_q;
  logic [7:0] corr_u_q;
  logic [10:0] remote_q;
  logic crit_used_q, crit_act_q;
  logic [7:0] status_q;
  logic die_over, remote_over, remote_under, crit_next;
  logic [7:0] cond;

  function automatic logic hit(input temp_limits_pkg::reg_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // ----------------------------------------
  // host writable registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      die_high_q <= `RST_DIE_HIGH;
      rhigh_u_q <= `RST_RHIGH_UPPER;
      rhigh_f_q <= 3'h0;
      rlow_u_q <= 8'h00;
      rlow_f_q <= 3'h0;
      corr_u_q <= 8'h00;
      corr_f_q <= 3'h0;
      hyst_q <= `RST_CRIT_HYST;
      cfg_q <= 8'h00;
      filt_q <= 8'h00;
    end else begin
      if (hit(REQ, `OFS_DIE_HIGH)) die_high_q <= REQ.wdata;
      if (hit(REQ, `OFS_RHIGH_UPPER)) rhigh_u_q <= REQ.wdata;
      if (hit(REQ, `OFS_RHIGH_FRAC)) rhigh_f_q <= REQ.wdata[7:5];
      if (hit(REQ, `OFS_RLOW_UPPER)) rlow_u_q <= REQ.wdata;
      if (hit(REQ, `OFS_RLOW_FRAC)) rlow_f_q <= REQ.wdata[7:5];
      if (hit(REQ, `OFS_CORR_UPPER)) corr_u_q <= REQ.wdata;
      if (hit(REQ, `OFS_CORR_LOWER)) corr_f_q <= REQ.wdata[7:5];
      if (hit(REQ, `OFS_CRIT_HYST)) hyst_q <= REQ.wdata;
      if (hit(REQ, `OFS_CONFIG)) cfg_q <= REQ.wdata;
      // upper bits masked to zero on write, only bits 2:0 kept
      if (hit(REQ, `OFS_FILTER_PIN)) filt_q <= REQ.wdata & `FILT_MASK;
    end
  end

  // ----------------------------------------
  // critical limit, one-shot reprogramming
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      crit_q <= `RST_CRIT_LIMIT;
      crit_used_q <= 1'b0;
    end else if (hit(REQ, `OFS_CRIT_LIMIT) && cfg_q[`CFG_UNLOCK_BIT] && !crit_used_q) begin
      crit_q <= REQ.wdata;
      crit_used_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // conversion results with correction
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      die_q <= 8'h00;
      remote_q <= 11'h000;
    end else if (CONV.valid) begin
      die_q <= CONV.die;
      remote_q <= CONV.remote + {corr_u_q, corr_f_q};
    end
  end

  limit_compare u_cmp (
    .remote(remote_q),
    .die(die_q),
    .die_high(die_high_q),
    .rhigh({rhigh_u_q, rhigh_f_q}),
    .rlow({rlow_u_q, rlow_f_q}),
    .crit(crit_q),
    .hyst(hyst_q),
    .crit_active(crit_act_q),
    .die_over(die_over),
    .remote_over(remote_over),
    .remote_under(remote_under),
    .crit_next(crit_next)
  );

  // one-cycle lag after the result register; harmless at conversion rates
  logic eval_q;
  always_ff @(posedge SYS_CLK) begin
    if (RST) eval_q <= 1'b0;
    else eval_q <= CONV.valid;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) crit_act_q <= 1'b0;
    else if (eval_q) crit_act_q <= crit_next;
  end

  // ----------------------------------------
  // status latch
  // ----------------------------------------
  always_comb begin
    cond = 8'h00;
    cond[`ST_DIE_HIGH_BIT] = die_over;
    cond[`ST_RHIGH_BIT] = remote_over;
    cond[`ST_RLOW_BIT] = remote_under;
    cond[`ST_CRIT_BIT] = crit_act_q;
  end

  logic st_read;
  assign st_read = REQ.rd && (REQ.addr == `OFS_STATUS);

  always_ff @(posedge SYS_CLK) begin
    if (RST) status_q <= 8'h00;
    else if (st_read) status_q <= cond;
    else status_q <= status_q | cond;
  end

  // ----------------------------------------
  // read mux, registered
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) RDATA <= 8'h00;
    else if (REQ.rd) begin
      case (REQ.addr)
        `OFS_DIE_TEMP: RDATA <= die_q;
        `OFS_REMOTE_UPPER: RDATA <= remote_q[10:3];
        `OFS_REMOTE_FRAC: RDATA <= {remote_q[2:0], 5'h00};
        `OFS_STATUS: RDATA <= status_q | cond;
        `OFS_CONFIG: RDATA <= cfg_q;
        `OFS_DIE_HIGH: RDATA <= die_high_q;
        `OFS_RHIGH_UPPER: RDATA <= rhigh_u_q;
        `OFS_RHIGH_FRAC: RDATA <= {rhigh_f_q, 5'h00};
        `OFS_RLOW_UPPER: RDATA <= rlow_u_q;
        `OFS_RLOW_FRAC: RDATA <= {rlow_f_q, 5'h00};
        `OFS_CORR_UPPER: RDATA <= corr_u_q;
        `OFS_CORR_LOWER: RDATA <= {corr_f_q, 5'h00};
        `OFS_CRIT_LIMIT: RDATA <= crit_q;
        `OFS_CRIT_HYST: RDATA <= hyst_q;
        `OFS_FILTER_PIN: RDATA <= filt_q;
        default: RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    case (filt_q[2:1])
      2'h0: FILTER_SEL = temp_limits_pkg::FILT_OFF;
      2'h3: FILTER_SEL = temp_limits_pkg::FILT_MAX;
      default: FILTER_SEL = temp_limits_pkg::FILT_MIN;
    endcase
  end
  assign ALERT_CMP_EN = filt_q[`CMP_MODE_BIT];
  // comparator mode: pin tracks live condition, else latched status
  assign ALERT_LEVEL = filt_q[`CMP_MODE_BIT] ? (|cond) : (|status_q);
  assign CRIT_ACTIVE = crit_act_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_crit_lock: assert property (@(posedge SYS_CLK) disable iff (RST)
    crit_used_q |=> $stable(crit_q)) else $error("critical limit changed twice");
  a_crit_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    !cfg_q[`CFG_UNLOCK_BIT] |=> $stable(crit_q)) else $error("locked limit changed");
  a_offset_add: assert property (@(posedge SYS_CLK) disable iff (RST)
    CONV.valid |=> remote_q == 11'($past(CONV.remote) + $past({corr_u_q, corr_f_q})))
    else $error("offset not applied");
  a_status_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    (status_q[`ST_RHIGH_BIT] && !st_read) |=> status_q[`ST_RHIGH_BIT]) else $error("alarm lost");
  a_rhigh_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    remote_over |=> status_q[`ST_RHIGH_BIT]) else $error("high alarm not set");
  a_rlow_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    remote_under |=> status_q[`ST_RLOW_BIT]) else $error("low alarm not set");
  a_die_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    die_over |=> status_q[`ST_DIE_HIGH_BIT]) else $error("die alarm not set");
  a_frac_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    $past(REQ.rd) && $past(REQ.addr) == `OFS_REMOTE_FRAC |-> RDATA[4:0] == 5'h00)
    else $error("fraction low bits nonzero");
  a_cmp_pin: assert property (@(posedge SYS_CLK) disable iff (RST)
    filt_q[`CMP_MODE_BIT] && cond == 8'h00 |-> !ALERT_LEVEL) else $error("pin held");
  a_crit_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    crit_act_q && !eval_q |=> crit_act_q) else $error("critical dropped");
  c_crit_write: cover property (@(posedge SYS_CLK) $rose(crit_used_q));
  c_crit_on: cover property (@(posedge SYS_CLK) $rose(crit_act_q));
  c_status_read: cover property (@(posedge SYS_CLK) st_read && status_q != 8'h00);
endmodule : temp_limit_regs
`default_nettype wire

// file: verilog/temp_limits_map.svh
`ifndef TEMP_LIMITS_MAP_SVH
`define TEMP_LIMITS_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_DIE_TEMP 8'h00
`define OFS_REMOTE_UPPER 8'h01
`define OFS_STATUS 8'h02
`define OFS_CONFIG 8'h03
`define OFS_DIE_HIGH 8'h05
`define OFS_RHIGH_UPPER 8'h07
`define OFS_RLOW_UPPER 8'h08
`define OFS_REMOTE_FRAC 8'h10
`define OFS_CORR_UPPER 8'h11
`define OFS_CORR_LOWER 8'h12
`define OFS_RHIGH_FRAC 8'h13
`define OFS_RLOW_FRAC 8'h14
`define OFS_CRIT_LIMIT 8'h19
`define OFS_CRIT_HYST 8'h21
`define OFS_FILTER_PIN 8'hBF
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_DIE_HIGH 8'h46
`define RST_RHIGH_UPPER 8'h46
`define RST_CRIT_LIMIT 8'h55
`define RST_CRIT_HYST 8'h0A
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_UNLOCK_BIT 1
`define CMP_MODE_BIT 0
`define ST_DIE_HIGH_BIT 6
`define ST_RHIGH_BIT 4
`define ST_RLOW_BIT 3
`define ST_CRIT_BIT 1
`define FRAC_MASK 8'hE0
`define FILT_MASK 8'h07
`endif

// file: verilog/temp_limits_pkg.sv
`default_nettype none
package temp_limits_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [7:0] die;
    logic [10:0] remote;
    logic valid;
  } conv_t;
  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_MIN = 2'h1,
    FILT_MAX = 2'h2
  } filt_t;
endpackage : temp_limits_pkg
`default_nettype wire
